// file: inc/uartc_pkg.sv
// Register map, field layout, reset values and trigger tables for the control block
package uartc_pkg;
  localparam logic [2:0] UARTC_OFS_DATA_LO = 3'h0;
  localparam logic [2:0] UARTC_OFS_DATA_HI = 3'h1;
  localparam logic [2:0] UARTC_OFS_FIFO = 3'h2;
  localparam logic [2:0] UARTC_OFS_LINE = 3'h3;
  localparam logic [2:0] UARTC_OFS_MODEM = 3'h4;

  localparam int UARTC_FIFO_EN = 0;
  localparam int UARTC_FIFO_RXFL = 1;
  localparam int UARTC_FIFO_TXFL = 2;
  localparam int UARTC_FIFO_TXTRIG = 4;
  localparam int UARTC_FIFO_RXTRIG = 6;

  localparam int UARTC_LINE_LEN = 0;
  localparam int UARTC_LINE_STOP = 2;
  localparam int UARTC_LINE_PEN = 3;
  localparam int UARTC_LINE_PSEL = 4;
  localparam int UARTC_LINE_BRK = 6;
  localparam int UARTC_LINE_DIV = 7;

  localparam int UARTC_MDM_DTR = 0;
  localparam int UARTC_MDM_RTS = 1;
  localparam int UARTC_MDM_AUX1 = 2;
  localparam int UARTC_MDM_AUX2 = 3;
  localparam int UARTC_MDM_LOOP = 4;
  localparam int UARTC_MDM_W = 5;

  localparam logic [7:0] UARTC_LINE_RST = 8'h03;
  localparam logic [UARTC_MDM_W-1:0] UARTC_MDM_RST = 5'h00;
  localparam logic [1:0] UARTC_TRIG_RST = 2'h0;
  localparam logic [1:0] UARTC_LEN_5BIT = 2'h0;

  // Stop length in half bit times
  localparam logic [2:0] UARTC_STOP_ONE = 3'h2;
  localparam logic [2:0] UARTC_STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] UARTC_STOP_TWO = 3'h4;

  localparam logic [6:0] UARTC_TX_TRIG_0 = 7'h10;
  localparam logic [6:0] UARTC_TX_TRIG_1 = 7'h20;
  localparam logic [6:0] UARTC_TX_TRIG_2 = 7'h40;
  localparam logic [6:0] UARTC_TX_TRIG_3 = 7'h70;
  localparam logic [6:0] UARTC_RX_TRIG_0 = 7'h01;
  localparam logic [6:0] UARTC_RX_TRIG_1 = 7'h04;
  localparam logic [6:0] UARTC_RX_TRIG_2 = 7'h08;
  localparam logic [6:0] UARTC_RX_TRIG_3 = 7'h0e;
  localparam logic [6:0] UARTC_RXE_TRIG_0 = 7'h0f;
  localparam logic [6:0] UARTC_RXE_TRIG_1 = 7'h1f;
  localparam logic [6:0] UARTC_RXE_TRIG_2 = 7'h3f;
  localparam logic [6:0] UARTC_RXE_TRIG_3 = 7'h6f;

  typedef enum logic [1:0] {
    UARTC_PAR_ODD,
    UARTC_PAR_EVEN,
    UARTC_PAR_MARK,
    UARTC_PAR_SPACE
  } uartc_parity_t;

  function automatic logic [6:0] uartc_tx_level(input logic [1:0] code);
    case (code)
      2'h0: uartc_tx_level = UARTC_TX_TRIG_0;
      2'h1: uartc_tx_level = UARTC_TX_TRIG_1;
      2'h2: uartc_tx_level = UARTC_TX_TRIG_2;
      default: uartc_tx_level = UARTC_TX_TRIG_3;
    endcase
  endfunction

  function automatic logic [6:0] uartc_rx_level(input logic [1:0] code, input logic enh);
    case (code)
      2'h0: uartc_rx_level = enh ? UARTC_RXE_TRIG_0 : UARTC_RX_TRIG_0;
      2'h1: uartc_rx_level = enh ? UARTC_RXE_TRIG_1 : UARTC_RX_TRIG_1;
      2'h2: uartc_rx_level = enh ? UARTC_RXE_TRIG_2 : UARTC_RX_TRIG_2;
      default: uartc_rx_level = enh ? UARTC_RXE_TRIG_3 : UARTC_RX_TRIG_3;
    endcase
  endfunction
endpackage

// file: src/uartc_loop.sv
// Serial and modem line routing with internal loopback
`timescale 1ns/1ps
`default_nettype none
module uartc_loop
  import uartc_pkg::*;
(
  input wire logic loopback, // Internal loopback active
  input wire logic send_break, // Hold line in space
  input wire logic tx_serial, // Transmitter serial bit
  input wire logic dtr, // Terminal ready, active high
  input wire logic rts, // Request to send, active high
  input wire logic aux_output_one, // General output one
  input wire logic aux_output_two, // General output two
  input wire logic rxd_pin, // Serial input pin
  input wire logic cts_pin_n, // Clear-to-send pin
  input wire logic dsr_pin_n, // Set-ready pin
  input wire logic ri_pin_n, // Ring pin
  input wire logic dcd_pin_n, // Carrier pin
  output logic txd_pin, // Serial output pin
  output logic rx_serial, // Bit to the receiver
  output logic cts, // Clear-to-send to status path
  output logic dsr, // Set-ready to status path
  output logic ri, // Ring to status path
  output logic dcd // Carrier to status path
);
  logic line_bit;

  always_comb begin
    line_bit = send_break ? 1'b0 : tx_serial;
    // Pin idles at mark in loopback so the remote sees no activity
    txd_pin = loopback ? 1'b1 : line_bit;
    rx_serial = loopback ? line_bit : rxd_pin;
    cts = loopback ? rts : ~cts_pin_n;
    dsr = loopback ? dtr : ~dsr_pin_n;
    ri = loopback ? aux_output_one : ~ri_pin_n;
    dcd = loopback ? aux_output_two : ~dcd_pin_n;
  end
endmodule
`default_nettype wire

// file: src/uartc_ctrl.sv
// FIFO, line and modem control registers of one serial channel
// Summary of operation
// - FIFO control bit 0 enables FIFO operation; resets to zero.
// - FIFO control bit 1 flushes receive FIFO, then clears itself.
// - FIFO control bit 2 flushes transmit FIFO, then clears itself.
// - Transmit trigger codes give 16, 32, 64, 112 in either mode; reset 00.
// - Normal receive trigger codes give 1, 4, 8, 14; reset 00.
// - Enhanced receive trigger codes give 15, 31, 63, 111.
// - Line bits 1:0 pick 5 to 8 data bits; reset 11.
// - Line bit 6 holds serial output at space for break when not in loopback.
// - Line bit 7 steers shared offsets to divisor latch; reset zero.
// - Modem bit 0 drives terminal-ready pin inverted; reset zero.
// - Modem bit 1 drives request-to-send pin inverted; reset zero.
// - Modem bit 4 enables internal loopback; reset zero.
// - In loopback, aux output one replaces the ring input.
// - In loopback, aux output two replaces the carrier input.
`timescale 1ns/1ps
`default_nettype none
module uartc_ctrl
  import uartc_pkg::*;
(
  input wire logic core_clk, // Core clock, 25 MHz
  input wire logic reset, // Async reset, active high
  input wire logic [2:0] reg_addr, // Byte offset in channel window
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, next cycle
  input wire logic enhanced_mode, // Enhanced operation select
  output logic divisor_select, // Shared offsets go to divisor
  output logic divisor_wr, // Write aimed at divisor latch
  output logic data_wr, // Write aimed at data registers
  output logic fifo_enable, // FIFO operation on
  output logic rx_flush, // Receive FIFO flush pulse
  output logic tx_flush, // Transmit FIFO flush pulse
  output logic [6:0] tx_level, // Transmit trigger threshold
  output logic [6:0] rx_level, // Receive trigger threshold
  output logic [3:0] char_bits, // Data bits per character
  output logic [2:0] stop_halves, // Stop length in half bits
  output logic parity_enable, // Parity bit present
  output logic [1:0] parity_kind, // Parity flavour
  output logic send_break, // Break being sent
  output logic loopback, // Internal loopback on
  input wire logic tx_serial, // Transmitter serial bit
  output logic rx_serial, // Bit to the receiver
  input wire logic rxd_pin, // Serial input pin
  output logic txd_pin, // Serial output pin
  output logic dtr_pin_n, // Terminal-ready pin
  output logic rts_pin_n, // Request-to-send pin
  input wire logic cts_pin_n, // Clear-to-send pin
  input wire logic dsr_pin_n, // Set-ready pin
  input wire logic ri_pin_n, // Ring pin
  input wire logic dcd_pin_n, // Carrier pin
  output logic cts, // Clear-to-send to status path
  output logic dsr, // Set-ready to status path
  output logic ri, // Ring to status path
  output logic dcd // Carrier to status path
);
  typedef struct packed {
    logic [7:0] line;
    logic [UARTC_MDM_W-1:0] modem;
    logic fifo_en;
    logic rx_fl;
    logic tx_fl;
    logic [1:0] tx_trig;
    logic [1:0] rx_trig;
    logic [6:0] tx_lvl;
    logic [6:0] rx_lvl;
    logic [7:0] rdata;
  } uartc_state_t;

  localparam uartc_state_t UARTC_STATE_RST = '{
    line: UARTC_LINE_RST, modem: UARTC_MDM_RST, fifo_en: 1'b0, rx_fl: 1'b0,
    tx_fl: 1'b0, tx_trig: UARTC_TRIG_RST, rx_trig: UARTC_TRIG_RST,
    tx_lvl: UARTC_TX_TRIG_0, rx_lvl: UARTC_RX_TRIG_0, rdata: 8'h00};

  uartc_state_t st;
  uartc_state_t next_st;

  function automatic logic is_shared(input logic [2:0] a);
    is_shared = (a == UARTC_OFS_DATA_LO) || (a == UARTC_OFS_DATA_HI);
  endfunction

  always_comb begin
    next_st = st;
    // Flush is a single cycle reset of the FIFO pointers, so it is done at once
    next_st.rx_fl = 1'b0;
    next_st.tx_fl = 1'b0;
    next_st.rdata = 8'h00;
    if (reg_wr && reg_addr == UARTC_OFS_FIFO) begin
      next_st.fifo_en = reg_wdata[UARTC_FIFO_EN];
      next_st.rx_fl = reg_wdata[UARTC_FIFO_RXFL];
      next_st.tx_fl = reg_wdata[UARTC_FIFO_TXFL];
      next_st.tx_trig = reg_wdata[UARTC_FIFO_TXTRIG +: 2];
      next_st.rx_trig = reg_wdata[UARTC_FIFO_RXTRIG +: 2];
    end else if (reg_wr && reg_addr == UARTC_OFS_LINE) begin
      next_st.line = reg_wdata;
    end else if (reg_wr && reg_addr == UARTC_OFS_MODEM) begin
      next_st.modem = reg_wdata[UARTC_MDM_W-1:0];
    end
    // Fifo control is write only; its offset reads back as zero from this block
    if (reg_rd && reg_addr == UARTC_OFS_LINE) begin
      next_st.rdata = st.line;
    end else if (reg_rd && reg_addr == UARTC_OFS_MODEM) begin
      next_st.rdata = {{(8-UARTC_MDM_W){1'b0}}, st.modem};
    end
    next_st.tx_lvl = uartc_tx_level(st.tx_trig);
    next_st.rx_lvl = uartc_rx_level(st.rx_trig, enhanced_mode);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st <= UARTC_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    reg_rdata = st.rdata;
    fifo_enable = st.fifo_en;
    rx_flush = st.rx_fl;
    tx_flush = st.tx_fl;
    tx_level = st.tx_lvl;
    rx_level = st.rx_lvl;
    divisor_select = st.line[UARTC_LINE_DIV];
    divisor_wr = reg_wr && is_shared(reg_addr) && st.line[UARTC_LINE_DIV];
    data_wr = reg_wr && is_shared(reg_addr) && !st.line[UARTC_LINE_DIV];
    char_bits = 4'h5 + {2'h0, st.line[UARTC_LINE_LEN +: 2]};
    if (!st.line[UARTC_LINE_STOP]) begin
      stop_halves = UARTC_STOP_ONE;
    end else if (st.line[UARTC_LINE_LEN +: 2] == UARTC_LEN_5BIT) begin
      stop_halves = UARTC_STOP_ONE_HALF;
    end else begin
      stop_halves = UARTC_STOP_TWO;
    end
    parity_enable = st.line[UARTC_LINE_PEN];
    parity_kind = st.line[UARTC_LINE_PSEL +: 2];
    send_break = st.line[UARTC_LINE_BRK];
    loopback = st.modem[UARTC_MDM_LOOP];
    // Pins are driven straight from the register to avoid an extra cycle of skew
    dtr_pin_n = ~st.modem[UARTC_MDM_DTR];
    rts_pin_n = ~st.modem[UARTC_MDM_RTS];
  end

  uartc_loop u_loop (
    .loopback(st.modem[UARTC_MDM_LOOP]),
    .send_break(st.line[UARTC_LINE_BRK]),
    .tx_serial(tx_serial),
    .dtr(st.modem[UARTC_MDM_DTR]),
    .rts(st.modem[UARTC_MDM_RTS]),
    .aux_output_one(st.modem[UARTC_MDM_AUX1]),
    .aux_output_two(st.modem[UARTC_MDM_AUX2]),
    .rxd_pin(rxd_pin),
    .cts_pin_n(cts_pin_n),
    .dsr_pin_n(dsr_pin_n),
    .ri_pin_n(ri_pin_n),
    .dcd_pin_n(dcd_pin_n),
    .txd_pin(txd_pin),
    .rx_serial(rx_serial),
    .cts(cts),
    .dsr(dsr),
    .ri(ri),
    .dcd(dcd)
  );

  sequence s_fifo_write;
    reg_wr && reg_addr == UARTC_OFS_FIFO;
  endsequence

  sequence s_flush_rx_req;
    s_fifo_write and reg_wdata[UARTC_FIFO_RXFL];
  endsequence

  sequence s_flush_tx_req;
    s_fifo_write and reg_wdata[UARTC_FIFO_TXFL];
  endsequence

  a_fifo_enable_write: assert property (@(posedge core_clk) disable iff (reset)
    s_fifo_write |=> fifo_enable == $past(reg_wdata[UARTC_FIFO_EN]))
    else $error("FIFO enable did not follow write");

  // Pulse shows in the cycle after the write and is gone one cycle later
  a_rx_flush_pulse: assert property (@(posedge core_clk) disable iff (reset)
    s_flush_rx_req ##1 !(reg_wr && reg_addr == UARTC_OFS_FIFO) |-> rx_flush ##1 !rx_flush)
    else $error("Receive flush not a single pulse");

  a_tx_flush_pulse: assert property (@(posedge core_clk) disable iff (reset)
    s_flush_tx_req ##1 !(reg_wr && reg_addr == UARTC_OFS_FIFO) |-> tx_flush ##1 !tx_flush)
    else $error("Transmit flush not a single pulse");

  a_tx_trigger_level: assert property (@(posedge core_clk) disable iff (reset)
    s_fifo_write ##1 !(reg_wr && reg_addr == UARTC_OFS_FIFO) |=>
      tx_level == uartc_tx_level($past(reg_wdata[UARTC_FIFO_TXTRIG +: 2], 2)))
    else $error("Transmit threshold wrong");

  a_rx_trigger_level: assert property (@(posedge core_clk) disable iff (reset)
    s_fifo_write ##1 (!(reg_wr && reg_addr == UARTC_OFS_FIFO) && $stable(enhanced_mode)) |=>
      rx_level == uartc_rx_level($past(reg_wdata[UARTC_FIFO_RXTRIG +: 2], 2),
                                 $past(enhanced_mode)))
    else $error("Receive threshold wrong");

  a_char_length: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr && reg_addr == UARTC_OFS_LINE |=>
      char_bits == 4'h5 + {2'h0, $past(reg_wdata[UARTC_LINE_LEN +: 2])})
    else $error("Character length wrong");

  a_break_line: assert property (@(posedge core_clk) disable iff (reset)
    send_break && !loopback |-> !txd_pin)
    else $error("Break not held at space");

  a_divisor_steer: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr && is_shared(reg_addr) |-> divisor_wr == divisor_select && data_wr != divisor_select)
    else $error("Shared offset misrouted");

  a_modem_pins: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr && reg_addr == UARTC_OFS_MODEM |=>
      dtr_pin_n == !$past(reg_wdata[UARTC_MDM_DTR])
      && rts_pin_n == !$past(reg_wdata[UARTC_MDM_RTS]))
    else $error("Modem pin polarity wrong");

  a_loop_inputs: assert property (@(posedge core_clk) disable iff (reset)
    loopback |-> ri == st.modem[UARTC_MDM_AUX1]
                 && dcd == st.modem[UARTC_MDM_AUX2] && cts == !rts_pin_n && dsr == !dtr_pin_n)
    else $error("Loopback inputs not routed");

  a_loop_serial: assert property (@(posedge core_clk) disable iff (reset)
    loopback |-> txd_pin && rx_serial == (tx_serial && !send_break))
    else $error("Loopback serial path wrong");
endmodule
`default_nettype wire

// file: verif/uartc_remote.sv
// Remote serial device model driving the serial input and modem status pins
`timescale 1ns/1ps
`default_nettype none
module uartc_remote (
  input wire logic [4:0] lines, // Asserted levels: rxd, cts, dsr, ri, dcd
  output logic rxd_pin, // Serial data toward the channel
  output logic cts_pin_n, // Clear-to-send, active low
  output logic dsr_pin_n, // Set-ready, active low
  output logic ri_pin_n, // Ring, active low
  output logic dcd_pin_n // Carrier, active low
);
  // Cable lines are always driven, so no released state to model
  assign rxd_pin = lines[0];
  assign cts_pin_n = ~lines[1];
  assign dsr_pin_n = ~lines[2];
  assign ri_pin_n = ~lines[3];
  assign dcd_pin_n = ~lines[4];
endmodule
`default_nettype wire

// file: verif/uartc_ctrl_tb.sv
// Self-checking bench for the channel control block
`timescale 1ns/1ps
`default_nettype none
module uartc_ctrl_tb;
  import uartc_pkg::*;
  logic core_clk, reset, reg_wr, reg_rd, enhanced_mode, tx_serial;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, cur_line, cur_mdm, v;
  logic divisor_select, divisor_wr, data_wr, fifo_enable, rx_flush, tx_flush, parity_enable;
  logic send_break, loopback, rx_serial, txd_pin, dtr_pin_n, rts_pin_n, cts, dsr, ri, dcd;
  logic rxd_pin, cts_pin_n, dsr_pin_n, ri_pin_n, dcd_pin_n;
  logic [6:0] tx_level, rx_level;
  logic [3:0] char_bits;
  logic [2:0] stop_halves;
  logic [1:0] parity_kind;
  logic [4:0] lines;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [6:0] tx_tab [4] = '{7'h10, 7'h20, 7'h40, 7'h70};
  logic [6:0] rx_tab [4] = '{7'h01, 7'h04, 7'h08, 7'h0e};
  logic [6:0] rxe_tab [4] = '{7'h0f, 7'h1f, 7'h3f, 7'h6f};
  int err_total = 0;
  int compares = 0;

  uartc_ctrl u_dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .enhanced_mode(enhanced_mode),
    .divisor_select(divisor_select), .divisor_wr(divisor_wr), .data_wr(data_wr),
    .fifo_enable(fifo_enable), .rx_flush(rx_flush), .tx_flush(tx_flush), .tx_level(tx_level),
    .rx_level(rx_level), .char_bits(char_bits), .stop_halves(stop_halves),
    .parity_enable(parity_enable), .parity_kind(parity_kind), .send_break(send_break),
    .loopback(loopback), .tx_serial(tx_serial), .rx_serial(rx_serial), .rxd_pin(rxd_pin),
    .txd_pin(txd_pin), .dtr_pin_n(dtr_pin_n), .rts_pin_n(rts_pin_n), .cts_pin_n(cts_pin_n),
    .dsr_pin_n(dsr_pin_n), .ri_pin_n(ri_pin_n), .dcd_pin_n(dcd_pin_n), .cts(cts), .dsr(dsr),
    .ri(ri), .dcd(dcd));

  uartc_remote u_remote (.lines(lines), .rxd_pin(rxd_pin), .cts_pin_n(cts_pin_n),
    .dsr_pin_n(dsr_pin_n), .ri_pin_n(ri_pin_n), .dcd_pin_n(dcd_pin_n));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Steering strobes are combinational, so they are looked at before the edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    #1;
    chk("data_wr", 8'(a < 3'h2 && !cur_line[7]), 8'(data_wr));
    chk("divisor_wr", 8'(a < 3'h2 && cur_line[7]), 8'(divisor_wr));
    @(negedge core_clk);
    reg_wr = 1'b0;
    if (a == UARTC_OFS_LINE) cur_line = d;
    if (a == UARTC_OFS_MODEM) cur_mdm = {3'h0, d[4:0]};
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge core_clk);
    reg_rd = 1'b0;
  endtask

  // Read data is only valid one cycle after the strobe
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) chk("read_note", 8'h01, 8'h00);
      else chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
  end

  task automatic link_chk;
    logic [31:0] r;
    logic lb;
    logic br;
    r = $urandom;
    @(negedge core_clk);
    tx_serial = r[5];
    lines = r[4:0];
    #1;
    lb = cur_mdm[4];
    br = cur_line[6];
    chk("txd_pin", 8'(lb | (~br & tx_serial)), 8'(txd_pin));
    chk("rx_serial", 8'(lb ? (~br & tx_serial) : lines[0]), 8'(rx_serial));
    chk("modem_in", 8'(lb ? {cur_mdm[3:2], cur_mdm[0], cur_mdm[1]} : lines[4:1]),
      8'({dcd, ri, dsr, cts}));
  endtask

  task automatic reset_chk;
    cur_line = 8'h03;
    cur_mdm = 8'h00;
    chk("char_bits", 8'h08, 8'(char_bits));
    chk("stop_halves", 8'h02, 8'(stop_halves));
    chk("flags", 8'h00, 8'({divisor_select, send_break, parity_enable}));
    chk("modem_pins", 8'h03, 8'({dtr_pin_n, rts_pin_n}));
    chk("loop_fifo", 8'h00, 8'({loopback, fifo_enable}));
    chk("tx_level", 8'h10, 8'(tx_level));
    chk("rx_level", 8'h01, 8'(rx_level));
    rd(UARTC_OFS_LINE, 8'h03);
    rd(UARTC_OFS_MODEM, 8'h00);
    $display("test reset done");
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    final_report;
  end

  initial begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata, enhanced_mode} = {1'b1, 14'h0000};
    tx_serial = 1'b1;
    lines = 5'h01;
    void'($urandom(32'ha07975d6));
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    reset_chk;
    for (int i = 0; i < 16; i++) begin
      v = 8'($urandom);
      v[1:0] = i[1:0];
      v[5:4] = i[3:2];
      wr(UARTC_OFS_LINE, v);
      chk("char_bits", 8'(v[1:0]) + 8'h05, 8'(char_bits));
      chk("stop_halves", 8'(!v[2] ? 3'h2 : (~|v[1:0] ? 3'h3 : 3'h4)), 8'(stop_halves));
      chk("parity", 8'(v[5:3]), 8'({parity_kind, parity_enable}));
      chk("div_break", 8'(v[7:6]), 8'({divisor_select, send_break}));
      wr(3'(i % 2), v);
      rd(UARTC_OFS_LINE, v);
      link_chk;
    end
    // Unmapped and write-only places read as zero; writes to unmapped places are dropped
    wr(3'h6, 8'hff);
    rd(UARTC_OFS_FIFO, 8'h00);
    rd(3'h5, 8'h00);
    rd(UARTC_OFS_LINE, cur_line);
    $display("test line done");
    for (int i = 0; i < 8; i++) begin
      enhanced_mode = i[2];
      v = {i[1:0], i[1:0], 1'b0, i[1:0], i[2]};
      wr(UARTC_OFS_FIFO, v);
      chk("fifo_pulse", 8'(v[2:0]), 8'({tx_flush, rx_flush, fifo_enable}));
      @(negedge core_clk);
      chk("flush_clear", 8'h00, 8'({tx_flush, rx_flush}));
      chk("tx_level", 8'(tx_tab[i[1:0]]), 8'(tx_level));
      chk("rx_level", 8'(i[2] ? rxe_tab[i[1:0]] : rx_tab[i[1:0]]), 8'(rx_level));
    end
    $display("test fifo done");
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      v[4] = i[0];
      wr(UARTC_OFS_MODEM, v);
      chk("modem_out", 8'({~v[1:0], v[4]}),
        8'({rts_pin_n, dtr_pin_n, loopback}));
      rd(UARTC_OFS_MODEM, {3'h0, v[4:0]});
      link_chk;
      link_chk;
    end
    $display("test modem done");
    @(negedge core_clk);
    enhanced_mode = 1'b0;
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    reset_chk;
    // Let the read monitor see the last pending read before the verdict
    @(negedge core_clk);
    final_report;
  end
endmodule
`default_nettype wire
